/* File: hw/rctc_trim_ctrl.v */
// Clock reference and crystal trim control with host register port.
// Assumes one 100 MHz clock; host strobes synchronous to it.
`timescale 1ns/10ps
`include "rctc_regs.vh"
module rctc_trim_ctrl (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Register port
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  // Mode events
  input  wire        ref_supply_pin_config_cmd,
  input  wire        cold_wake,
  input  wire        slow_tick,
  // Trim and oscillator controls
  output reg  [7:0]  crystal_pin_a_trim,
  output reg  [7:0]  crystal_pin_b_trim,
  output reg         crystal_standby_mode,
  output reg         fast_rc_oscillator_en,
  output reg         slow_rc_oscillator_en,
  output reg         ref_supply_pin_en,
  output reg  [7:0]  ref_supply_voltage,
  output reg  [15:0] pa_ramp_time,
  output reg  [4:0]  tx_power_range,
  output reg         wake_event
);
  // Fast RC holdover after the last access, cycles
  localparam [3:0] FAST_RC_HOLD = 4'hF;

  reg        standby_q;
  reg        sleep_q;
  reg        tcxo_q;
  reg [15:0] wake_period_q;
  reg [3:0]  fast_hold_q;
  wire       wake_pulse;

  // Saturating clamp used by two programmable fields, reference voltage and PA ramp
  function [15:0] clamp16;
    input [15:0] val;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (val < lo)
        clamp16 = lo;
      else if (val > hi)
        clamp16 = hi;
      else
        clamp16 = val;
    end
  endfunction

  function [7:0] trim_sat;
    input [7:0] code;
    begin
      // Codes above max pin at max; no code disconnects the cap
      trim_sat = (code > `RCTC_TRIM_MAX) ? `RCTC_TRIM_MAX : code;
    end
  endfunction

  wire wr_trim_a = reg_wr && reg_addr == `RCTC_OFF_TRIM_A;
  wire wr_trim_b = reg_wr && reg_addr == `RCTC_OFF_TRIM_B;
  wire wr_mode   = reg_wr && reg_addr == `RCTC_OFF_MODE_CTRL;
  wire stdby_req = wr_mode && reg_wdata[`RCTC_MODE_STDBY_BIT];
  wire stdby_entry = stdby_req && !standby_q;
  wire sleep_req = wr_mode && reg_wdata[`RCTC_MODE_COLD_BIT];
  // Clamp at full width, then keep the byte that the field holds
  wire [15:0] vref_clamped = clamp16({8'h00, reg_wdata},
    {8'h00, `RCTC_VREF_MIN}, {8'h00, `RCTC_VREF_MAX});

  rctc_slow_timer u_slow_timer (
    .clock      (clock),
    .rst        (rst),
    .enable     (sleep_q),
    .period     (wake_period_q),
    .slow_tick  (slow_tick),
    .wake_pulse (wake_pulse)
  );

  // Mode state
  always @(posedge clock) begin
    if (rst) begin
      standby_q <= 1'b0;
      sleep_q   <= 1'b0;
      tcxo_q    <= 1'b0;
    end else begin
      if (ref_supply_pin_config_cmd)
        tcxo_q <= 1'b1;
      if (wr_mode)
        standby_q <= reg_wdata[`RCTC_MODE_STDBY_BIT];
      if (sleep_req)
        sleep_q <= 1'b1;
      else if (wake_pulse || cold_wake)
        sleep_q <= 1'b0;
    end
  end

  // Trim registers; command and standby forcing beat host writes
  always @(posedge clock) begin
    if (rst) begin
      crystal_pin_a_trim <= `RCTC_TRIM_POR;
      crystal_pin_b_trim <= `RCTC_TRIM_POR;
    end else begin
      if (cold_wake) begin
        crystal_pin_a_trim <= `RCTC_TRIM_POR;
        crystal_pin_b_trim <= `RCTC_TRIM_POR;
      end else if (stdby_entry) begin
        crystal_pin_a_trim <= `RCTC_TRIM_STDBY;
        crystal_pin_b_trim <= `RCTC_TRIM_STDBY;
      end else begin
        if (wr_trim_a)
          crystal_pin_a_trim <= trim_sat(reg_wdata);
        if (wr_trim_b)
          crystal_pin_b_trim <= trim_sat(reg_wdata);
      end
      if (ref_supply_pin_config_cmd)
        crystal_pin_a_trim <= `RCTC_TRIM_MAX;
    end
  end

  // Programmable analog settings
  always @(posedge clock) begin
    if (rst) begin
      ref_supply_voltage <= `RCTC_VREF_RST;
      pa_ramp_time       <= `RCTC_RAMP_RST_US;
      tx_power_range     <= 5'h00;
      wake_period_q      <= `RCTC_WAKE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `RCTC_OFF_REF_VOLT: begin
          ref_supply_voltage <= vref_clamped[7:0];
        end
        `RCTC_OFF_PA_RAMP: begin
          // Byte-wide port: value written in units of 16 us
          pa_ramp_time <= clamp16({4'h0, reg_wdata, 4'h0},
            `RCTC_RAMP_MIN_US, `RCTC_RAMP_MAX_US);
        end
        `RCTC_OFF_TX_POWER: begin
          // Step 0 is full power, each step 1 dB lower
          tx_power_range <= reg_wdata[4:0];
        end
        `RCTC_OFF_WAKE_PERIOD: begin
          wake_period_q <= {reg_wdata, 8'h00};
        end
        default: begin
        end
      endcase
    end
  end

  // Oscillator enables and registered outputs
  always @(posedge clock) begin
    if (rst) begin
      fast_hold_q           <= 4'h0;
      fast_rc_oscillator_en <= 1'b1;
      slow_rc_oscillator_en <= 1'b0;
      crystal_standby_mode  <= 1'b0;
      ref_supply_pin_en     <= 1'b0;
      wake_event            <= 1'b0;
    end else begin
      // Holdover keeps the RC running across back-to-back accesses
      if (reg_wr || reg_rd)
        fast_hold_q <= FAST_RC_HOLD;
      else if (fast_hold_q != 4'h0)
        fast_hold_q <= fast_hold_q - 4'h1;
      fast_rc_oscillator_en <= reg_wr || reg_rd ||
                               fast_hold_q != 4'h0 || !sleep_q;
      slow_rc_oscillator_en <= sleep_q;
      // Command cycle counts too, so standby never shows with the pin on
      crystal_standby_mode  <= standby_q && !tcxo_q &&
                               !ref_supply_pin_config_cmd;
      ref_supply_pin_en     <= tcxo_q || ref_supply_pin_config_cmd;
      wake_event            <= wake_pulse;
    end
  end

  // Read data in the cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `RCTC_OFF_TRIM_A:      reg_rdata <= crystal_pin_a_trim;
        `RCTC_OFF_TRIM_B:      reg_rdata <= crystal_pin_b_trim;
        `RCTC_OFF_MODE_CTRL:   reg_rdata <= {7'h00, standby_q};
        `RCTC_OFF_REF_VOLT:    reg_rdata <= ref_supply_voltage;
        `RCTC_OFF_PA_RAMP:     reg_rdata <= pa_ramp_time[11:4];
        `RCTC_OFF_TX_POWER:    reg_rdata <= {3'h0, tx_power_range};
        `RCTC_OFF_STATUS:      reg_rdata <= {5'h00, sleep_q, tcxo_q,
                                             standby_q};
        `RCTC_OFF_WAKE_PERIOD: reg_rdata <= wake_period_q[15:8];
        default:               reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // rctc_trim_ctrl

/* File: hw/rctc_regs.vh */
// Register map, reset values and timing constants for the clock trim block.
// Included by the clock trim control module rctc_trim_ctrl; definitions only.
`ifndef RCTC_REGS_VH
`define RCTC_REGS_VH

// Register indices (documented) and block-local registers
`define RCTC_ADDR_W          16
`define RCTC_OFF_TRIM_A      16'h0911
`define RCTC_OFF_TRIM_B      16'h0912
`define RCTC_OFF_MODE_CTRL   16'h0920
`define RCTC_OFF_REF_VOLT    16'h0921
`define RCTC_OFF_PA_RAMP     16'h0922
`define RCTC_OFF_TX_POWER    16'h0923
`define RCTC_OFF_STATUS      16'h0924
`define RCTC_OFF_WAKE_PERIOD 16'h0925

// Trim codes
`define RCTC_TRIM_MIN        8'h00
`define RCTC_TRIM_MAX        8'h2F
`define RCTC_TRIM_POR        8'h05
`define RCTC_TRIM_STDBY      8'h12

// Mode control bits
`define RCTC_MODE_STDBY_BIT  0
`define RCTC_MODE_COLD_BIT   1

// Reference supply voltage, tenths of a volt
`define RCTC_VREF_MIN        8'h10
`define RCTC_VREF_MAX        8'h21
`define RCTC_VREF_RST        8'h10

// PA ramp time in microseconds
`define RCTC_RAMP_MIN_US     16'h000A
`define RCTC_RAMP_MAX_US     16'h0D48
`define RCTC_RAMP_RST_US     16'h000A

// Transmit power step, 0 = highest, 31 = lowest
`define RCTC_PWR_STEP_MAX    8'h1F
`define RCTC_PWR_RST         8'h00

// Wake period in slow RC ticks
`define RCTC_WAKE_RST        16'h0040

`endif

/* File: hw/rctc_slow_timer.v */
// Slow RC tick counter for sleep wake-up timing.
// Assumes slow_tick is a one-cycle pulse synchronous to clock.
`timescale 1ns/10ps
module rctc_slow_timer (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Control
  input  wire        enable,
  input  wire [15:0] period,
  input  wire        slow_tick,
  // Event
  output reg         wake_pulse
);
  reg [15:0] count_q;

  always @(posedge clock) begin
    if (rst) begin
      count_q    <= 16'h0000;
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= 1'b0;
      if (!enable) begin
        count_q <= 16'h0000;
      end else if (slow_tick) begin
        // Period of zero would wake every tick; treated as one
        if (count_q + 16'h0001 >= period) begin
          count_q    <= 16'h0000;
          wake_pulse <= 1'b1;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end
endmodule // rctc_slow_timer

/* File: verif/rctc_trim_monitor.sv */
// Concurrent checks on the clock trim control block's ports.
// Assumes binding onto rctc_trim_ctrl; one clock, sync reset.
`timescale 1ns/10ps
module rctc_trim_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Host port and events
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        ref_supply_pin_config_cmd,
  input wire logic        cold_wake,
  // Controls
  input wire logic [7:0]  crystal_pin_a_trim,
  input wire logic [7:0]  crystal_pin_b_trim,
  input wire logic        crystal_standby_mode,
  input wire logic        fast_rc_oscillator_en,
  input wire logic        ref_supply_pin_en,
  input wire logic [15:0] pa_ramp_time
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence tcxo_cmd_s; ref_supply_pin_config_cmd; endsequence
  sequence tcxo_done_s;
    crystal_pin_a_trim == 8'h2F && ref_supply_pin_en;
  endsequence
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  tcxo_force_a: assert property (tcxo_cmd_s |=> tcxo_done_s)
    else $error("command did not force pin a trim");
  tcxo_latch_a: assert property (ref_supply_pin_en |=> ref_supply_pin_en)
    else $error("compensated mode left without reset");
  tcxo_no_stdby_a: assert property (ref_supply_pin_en |-> !crystal_standby_mode)
    else $error("standby shown in compensated mode");
  trim_range_a: assert property (crystal_pin_a_trim <= 8'h2F && crystal_pin_b_trim <= 8'h2F)
    else $error("trim code above maximum");
  stdby_load_a: assert property ($rose(crystal_standby_mode) |-> crystal_pin_a_trim == 8'h12 && crystal_pin_b_trim == 8'h12)
    else $error("standby entry did not load trims");
  cold_load_a: assert property (cold_wake && !ref_supply_pin_config_cmd && !ref_supply_pin_en |=> crystal_pin_a_trim == 8'h05 && crystal_pin_b_trim == 8'h05)
    else $error("cold wake did not load trims");
  access_fast_rc_a: assert property (reg_wr || reg_rd |=> fast_rc_oscillator_en [*2])
    else $error("fast rc off during host access");
  ramp_range_a: assert property (pa_ramp_time >= 16'h000A && pa_ramp_time <= 16'h0D48)
    else $error("ramp time out of range");
endmodule // rctc_trim_monitor

bind rctc_trim_ctrl rctc_trim_monitor rctc_trim_monitor_inst (
  .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cold_wake(cold_wake),
  .ref_supply_pin_config_cmd(ref_supply_pin_config_cmd),
  .crystal_pin_a_trim(crystal_pin_a_trim),
  .crystal_pin_b_trim(crystal_pin_b_trim),
  .crystal_standby_mode(crystal_standby_mode),
  .fast_rc_oscillator_en(fast_rc_oscillator_en),
  .ref_supply_pin_en(ref_supply_pin_en), .pa_ramp_time(pa_ramp_time));

/* File: verif/rctc_trim_ctrl_tb.sv */
// Self-checking bench for the clock trim control block.
// Drives host port and event pulses directly; no partner model.
`timescale 1ns/10ps
module rctc_trim_ctrl_tb;
  logic        clock, rst, reg_wr, reg_rd, stdby, fast_rc, slow_rc, ref_en;
  logic        wake;
  logic [15:0] reg_addr, ramp;
  logic [7:0]  reg_wdata, reg_rdata, trim_a, trim_b, vref, rd_v;
  logic [4:0]  tx_pwr;
  logic [2:0]  ev;
  int          fails, total_checks, ticks, wake_at;
  // Rows: address, write data, expected read back
  logic [31:0] rows [8] = '{32'h0911_20_20, 32'h0912_00_00, 32'h0911_2F_2F,
    32'h0912_30_2F, 32'h0921_21_21, 32'h0923_1F_1F, 32'h0930_55_00,
    32'h0922_10_10};
  rctc_trim_ctrl rctc_trim_ctrl_inst (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_supply_pin_config_cmd(ev[2]), .cold_wake(ev[1]), .slow_tick(ev[0]),
    .crystal_pin_a_trim(trim_a), .crystal_pin_b_trim(trim_b),
    .crystal_standby_mode(stdby), .fast_rc_oscillator_en(fast_rc),
    .slow_rc_oscillator_en(slow_rc), .ref_supply_pin_en(ref_en),
    .ref_supply_voltage(vref), .pa_ramp_time(ramp), .tx_power_range(tx_pwr),
    .wake_event(wake));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic pulse(input int i);
    @(posedge clock);
    ev[i] <= 1'b1;
    @(posedge clock);
    ev[i] <= 1'b0;
    #1;
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Counts ticks taken, notes the count when the wake pulse shows
  always @(posedge clock) begin
    if (ev[0] === 1'b1) ticks <= ticks + 1;
    if (wake === 1'b1 && wake_at < 0) wake_at <= ticks;
  end
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #300000;
    fails++;
    stop_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, ev} = {3'h4, 27'h0};
    {fails, total_checks, ticks, wake_at} = {32'h0, 32'h0, 32'h0, -32'sd1};
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk({trim_a, trim_b}, 16'h0505);
    chk({fast_rc, stdby, ref_en, tx_pwr}, 16'h0080);
    chk({vref, ramp[7:0]}, 16'h100A);
    // Trim written before standby must be overwritten on entry
    wr(16'h0911, 8'h33);
    wr(16'h0920, 8'h01);
    chk({trim_a, trim_b}, 16'h1212);
    @(posedge clock);
    #1 chk(stdby, 16'h0001);
    foreach (rows[i]) begin
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16]);
      chk(rd_v, rows[i][7:0]);
      chk(fast_rc, 16'h0001);
      @(posedge clock);
      #1 chk(reg_rdata, 16'h0000);
    end
    chk({vref, 3'h0, tx_pwr}, 16'h211F);
    chk(ramp, 16'h0100);
    wr(16'h0922, 8'hFF);
    chk(ramp, 16'h0D48);
    wr(16'h0922, 8'h00);
    chk(ramp, 16'h000A);
    pulse(1);
    chk({trim_a, trim_b}, 16'h0505);
    wr(16'h0920, 8'h02);
    @(posedge clock);
    #1 chk(slow_rc, 16'h0001);
    for (int n = 0; n < 100 && wake_at < 0; n++) pulse(0);
    if (wake_at < 0) begin
      fails++;
      stop_test();
    end
    chk(wake_at >= 64 && wake_at <= 65, 16'h0001);
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    wr(16'h0920, 8'h01);
    pulse(2);
    chk({trim_a, trim_b}, 16'h2F12);
    chk({ref_en, stdby}, 16'h0002);
    wr(16'h0920, 8'h01);
    pulse(1);
    chk({ref_en, stdby}, 16'h0002);
    @(posedge clock) rst <= 1'b1;
    @(posedge clock) rst <= 1'b0;
    #1 chk({ref_en, trim_a}, 16'h0005);
    stop_test();
  end
endmodule // rctc_trim_ctrl_tb
